// *** bcc_pkg.sv ***
// constants, field layout and state types of the bus-cycle configuration block
// assumes an apb master on pclk with 32-bit data and word-aligned registers
//
// Notes on behaviour
// - config register sits at index 1h; its fields steer dma bus cycles.
// - hardware reset clears extended-bus enable, latched retry and fixed bit 14; other bits keep value.
// - software reset (entering reset mode) leaves every config bit unchanged.
// - bits 15 ext-bus, 14 fixed zero, 13 retry, 12-11 outputs, 10 sync bus.
// - bits 9-8 user pins, 7-6 wait-state control, all read/write.
// - bit 5 width, 4 block dma, 3-2 rx threshold, 1-0 tx threshold.
package bcc_pkg;

   localparam int unsigned PADDR_W = 12;

   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CMD  = 4'h0;
   localparam logic [3:0] IDX_BCC  = 4'h1;
   localparam logic [3:0] IDX_STAT = 4'h2;

   // command register
   localparam int unsigned CMD_RESET_MODE  = 0;
   localparam logic        RESET_MODE_INIT = 1'b1;

   // status register
   localparam int unsigned STAT_VIOLATION = 0;
   localparam int unsigned STAT_LOADED    = 1;

   // config field positions
   localparam int unsigned BIT_EXT    = 15;
   localparam int unsigned BIT_FIXED  = 14;
   localparam int unsigned BIT_RETRY  = 13;
   localparam int unsigned BIT_PO_HI  = 12;
   localparam int unsigned BIT_PO_LO  = 11;
   localparam int unsigned BIT_SYNC   = 10;
   localparam int unsigned BIT_USR_HI = 9;
   localparam int unsigned BIT_USR_LO = 8;
   localparam int unsigned BIT_WS_HI  = 7;
   localparam int unsigned BIT_WS_LO  = 6;
   localparam int unsigned BIT_WIDTH  = 5;
   localparam int unsigned BIT_BLK    = 4;
   localparam int unsigned BIT_RXT_HI = 3;
   localparam int unsigned BIT_RXT_LO = 2;
   localparam int unsigned BIT_TXT_HI = 1;
   localparam int unsigned BIT_TXT_LO = 0;

   localparam logic [15:0] BCC_WRITE_MASK = 16'hBFFF;
   localparam logic        BCC_HW_CLEAR   = 1'b0;

   typedef struct packed {
      logic [15:0] cfg;
      logic        cfg_loaded;
      logic        reset_mode;
      logic        violation;
      logic        rdy;
      logic        err;
      logic [31:0] rdata;
   } bcc_state_t;

   typedef struct packed {
      logic [15:0] word;
   } bcc_fields_t;

   function automatic logic [PADDR_W-1:0] bcc_byte_addr(input logic [3:0] idx);
      return {6'h00, idx, 2'b00};
   endfunction

endpackage

// *** bcc_field_out.sv ***
// output stage: registers the config word onto the field pins
// assumes cfg_word comes from logic on the same pclk
`timescale 1ns/1ps
module bcc_field_out
   import bcc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // config word
   input  wire logic [15:0] cfg_word,
   // field pins
   output logic             extended_bus_enable,
   output logic             latched_retry,
   output logic             prog_output_sel_hi,
   output logic             prog_output_sel_lo,
   output logic             sync_bus_select,
   output logic             user_pin_hi,
   output logic             user_pin_lo,
   output logic             wait_state_hi,
   output logic             wait_state_lo,
   output logic             data_width_select,
   output logic             block_transfer_select,
   output logic             rx_fifo_threshold_hi,
   output logic             rx_fifo_threshold_lo,
   output logic             tx_fifo_threshold_hi,
   output logic             tx_fifo_threshold_lo
);

   bcc_fields_t f_q;
   bcc_fields_t f_d;

   always_comb begin
      f_d      = f_q;
      f_d.word = cfg_word;
   end

   // pins show zero until the first edge after reset, then track the word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_q <= '0;
      end else if (clk_en) begin
         f_q <= f_d;
      end
   end

   assign extended_bus_enable   = f_q.word[BIT_EXT];
   assign latched_retry         = f_q.word[BIT_RETRY];
   assign prog_output_sel_hi    = f_q.word[BIT_PO_HI];
   assign prog_output_sel_lo    = f_q.word[BIT_PO_LO];
   assign sync_bus_select       = f_q.word[BIT_SYNC];
   assign user_pin_hi           = f_q.word[BIT_USR_HI];
   assign user_pin_lo           = f_q.word[BIT_USR_LO];
   assign wait_state_hi         = f_q.word[BIT_WS_HI];
   assign wait_state_lo         = f_q.word[BIT_WS_LO];
   assign data_width_select     = f_q.word[BIT_WIDTH];
   assign block_transfer_select = f_q.word[BIT_BLK];
   assign rx_fifo_threshold_hi  = f_q.word[BIT_RXT_HI];
   assign rx_fifo_threshold_lo  = f_q.word[BIT_RXT_LO];
   assign tx_fifo_threshold_hi  = f_q.word[BIT_TXT_HI];
   assign tx_fifo_threshold_lo  = f_q.word[BIT_TXT_LO];

endmodule

// *** bcc_top.sv ***
// bus-cycle configuration register bank behind an apb slave port
// assumes one apb master on pclk; clk_en held high during transfers
`timescale 1ns/1ps
module bcc_top
   import bcc_pkg::*;
(
   // clock, reset, enable
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clk_en,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // controller state
   output logic                    ctrl_reset_mode,
   // config fields
   output logic                    extended_bus_enable,
   output logic                    latched_retry,
   output logic                    prog_output_sel_hi,
   output logic                    prog_output_sel_lo,
   output logic                    sync_bus_select,
   output logic                    user_pin_hi,
   output logic                    user_pin_lo,
   output logic                    wait_state_hi,
   output logic                    wait_state_lo,
   output logic                    data_width_select,
   output logic                    block_transfer_select,
   output logic                    rx_fifo_threshold_hi,
   output logic                    rx_fifo_threshold_lo,
   output logic                    tx_fifo_threshold_hi,
   output logic                    tx_fifo_threshold_lo
);

   bcc_state_t s_q;
   bcc_state_t s_d;

   logic setup_phase;
   logic access_done;
   logic hit_cmd;
   logic hit_bcc;
   logic hit_stat;
   logic bcc_locked;

   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && s_q.rdy;
   assign hit_cmd     = (paddr == bcc_byte_addr(IDX_CMD));
   assign hit_bcc     = (paddr == bcc_byte_addr(IDX_BCC));
   assign hit_stat    = (paddr == bcc_byte_addr(IDX_STAT));
   // config writes only land while the controller sits in reset mode; outside it a config access gets pslverr
   assign bcc_locked  = hit_bcc && !s_q.reset_mode;

   always_comb begin
      s_d     = s_q;
      s_d.rdy = 1'b0;
      s_d.err = 1'b0;

      // answer is prepared in setup so pready and prdata leave flops
      if (setup_phase) begin
         s_d.rdy   = 1'b1;
         s_d.err   = 1'b0;
         s_d.rdata = 32'h0000_0000;
         if (hit_cmd) begin
            s_d.rdata[CMD_RESET_MODE] = s_q.reset_mode;
         end else if (hit_bcc) begin
            s_d.rdata[15:0] = s_q.cfg;
            s_d.rdata[BIT_FIXED] = 1'b0;
            s_d.err = bcc_locked;
         end else if (hit_stat) begin
            s_d.rdata[STAT_VIOLATION] = s_q.violation;
            s_d.rdata[STAT_LOADED]    = s_q.cfg_loaded;
         end else begin
            s_d.err = 1'b1;
         end
      end

      // writes land at the completing edge only
      if (access_done && pwrite && !s_q.err) begin
         if (hit_cmd) begin
            // entering reset mode is the soft reset; config is untouched
            s_d.reset_mode = pwdata[CMD_RESET_MODE];
         end else if (hit_bcc) begin
            s_d.cfg        = pwdata[15:0] & BCC_WRITE_MASK;
            s_d.cfg_loaded = 1'b1;
         end else if (hit_stat && pwdata[STAT_VIOLATION]) begin
            s_d.violation = 1'b0;
         end
      end

      // a fresh violation beats a clear in the same cycle
      if (access_done && bcc_locked) begin
         s_d.violation = 1'b1;
      end
   end

   // of the config bits only ext-bus, retry and fixed bit 14 are reset; the rest keep whatever they held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.cfg[BIT_EXT]   <= BCC_HW_CLEAR;
         s_q.cfg[BIT_RETRY] <= BCC_HW_CLEAR;
         s_q.cfg[BIT_FIXED] <= 1'b0;
         s_q.cfg_loaded     <= 1'b0;
         s_q.reset_mode     <= RESET_MODE_INIT;
         s_q.violation      <= 1'b0;
         s_q.rdy            <= 1'b0;
         s_q.err            <= 1'b0;
         s_q.rdata          <= 32'h0000_0000;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign pready          = s_q.rdy;
   assign prdata          = s_q.rdata;
   assign pslverr         = s_q.err;
   assign ctrl_reset_mode = s_q.reset_mode;

   bcc_field_out bcc_field_out_i (
      .pclk                  (pclk),
      .presetn               (presetn),
      .clk_en                (clk_en),
      .cfg_word              (s_q.cfg),
      .extended_bus_enable   (extended_bus_enable),
      .latched_retry         (latched_retry),
      .prog_output_sel_hi    (prog_output_sel_hi),
      .prog_output_sel_lo    (prog_output_sel_lo),
      .sync_bus_select       (sync_bus_select),
      .user_pin_hi           (user_pin_hi),
      .user_pin_lo           (user_pin_lo),
      .wait_state_hi         (wait_state_hi),
      .wait_state_lo         (wait_state_lo),
      .data_width_select     (data_width_select),
      .block_transfer_select (block_transfer_select),
      .rx_fifo_threshold_hi  (rx_fifo_threshold_hi),
      .rx_fifo_threshold_lo  (rx_fifo_threshold_lo),
      .tx_fifo_threshold_hi  (tx_fifo_threshold_hi),
      .tx_fifo_threshold_lo  (tx_fifo_threshold_lo)
   );

   a_write_lands_cfg: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_done && pwrite && hit_bcc && s_q.reset_mode)
      |=> (s_q.cfg == ($past(pwdata[15:0]) & BCC_WRITE_MASK)) && s_q.cfg_loaded)
      else $error("config write did not land");

   a_locked_write_blocked: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_done && hit_bcc && !s_q.reset_mode)
      |=> $stable(s_q.cfg) && s_q.violation)
      else $error("config changed outside reset mode");

   a_hw_reset_clears: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (s_q.cfg[BIT_EXT] == 1'b0) && (s_q.cfg[BIT_RETRY] == 1'b0))
      else $error("hardware reset left ext-bus or retry set");

   a_soft_reset_keeps: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(s_q.reset_mode) |-> $stable(s_q.cfg))
      else $error("entering reset mode disturbed config");

   a_upper_fields_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.cfg_loaded)
      |=> extended_bus_enable == $past(s_q.cfg[15]) && latched_retry == $past(s_q.cfg[13])
          && prog_output_sel_hi == $past(s_q.cfg[12]) && prog_output_sel_lo == $past(s_q.cfg[11])
          && sync_bus_select == $past(s_q.cfg[10]))
      else $error("upper field pins wrong");

   a_middle_fields_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.cfg_loaded)
      |=> {user_pin_hi, user_pin_lo, wait_state_hi, wait_state_lo} == $past(s_q.cfg[9:6]))
      else $error("middle field pins wrong");

   a_lower_fields_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.cfg_loaded)
      |=> {data_width_select, block_transfer_select, rx_fifo_threshold_hi,
           rx_fifo_threshold_lo, tx_fifo_threshold_hi, tx_fifo_threshold_lo}
          == $past(s_q.cfg[5:0]))
      else $error("lower field pins wrong");

   a_fixed_bit_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (s_q.cfg[BIT_FIXED] == 1'b0) && !(pready && hit_bcc && prdata[BIT_FIXED]))
      else $error("bit 14 not zero");

endmodule

// *** bcc_top_bench.sv ***
// self-checking bench for the bus-cycle configuration block over apb
// assumes bcc_pkg and bcc_top are compiled first; 50 MHz pclk
`timescale 1ns/1ps
module bcc_top_bench;
   import bcc_pkg::*;

   localparam logic [PADDR_W-1:0] A_CMD  = 12'h000;
   localparam logic [PADDR_W-1:0] A_BCC  = 12'h004;
   localparam logic [PADDR_W-1:0] A_STAT = 12'h008;
   localparam logic [PADDR_W-1:0] A_BAD  = 12'h010;
   localparam logic [31:0]        ALL    = 32'hFFFFFFFF;

   logic               pclk    = 1'b0;
   logic               presetn = 1'b0;
   logic               clk_en  = 1'b1;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic [PADDR_W-1:0] paddr   = '0;
   logic [31:0]        pwdata  = '0;
   logic               pready;
   logic [31:0]        prdata;
   logic               pslverr;
   logic               ctrl_reset_mode;
   logic [15:0]        fp;
   logic [15:0]        pins;
   int                 fails       = 0;
   int                 check_count = 0;

   // bit 14 has no pin, so it is shown as zero
   assign pins = {fp[15], 1'b0, fp[13:0]};

   always #10 pclk = ~pclk;

   bcc_top bcc_top_i (
      .pclk                  (pclk),
      .presetn               (presetn),
      .clk_en                (clk_en),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .pready                (pready),
      .prdata                (prdata),
      .pslverr               (pslverr),
      .ctrl_reset_mode       (ctrl_reset_mode),
      .extended_bus_enable   (fp[15]),
      .latched_retry         (fp[13]),
      .prog_output_sel_hi    (fp[12]),
      .prog_output_sel_lo    (fp[11]),
      .sync_bus_select       (fp[10]),
      .user_pin_hi           (fp[9]),
      .user_pin_lo           (fp[8]),
      .wait_state_hi         (fp[7]),
      .wait_state_lo         (fp[6]),
      .data_width_select     (fp[5]),
      .block_transfer_select (fp[4]),
      .rx_fifo_threshold_hi  (fp[3]),
      .rx_fifo_threshold_lo  (fp[2]),
      .tx_fifo_threshold_hi  (fp[1]),
      .tx_fifo_threshold_lo  (fp[0])
   );
   assign fp[14] = 1'b0;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one idle cycle between transfers keeps every strobe to one assignment per step
   task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here; the watchdog ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_chk(input logic [PADDR_W-1:0] a, input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk("write pslverr", {31'h0, e}, {31'h0, err});
   endtask

   task automatic rd_chk(input logic [PADDR_W-1:0] a, input logic [31:0] m,
                         input logic [31:0] exp, input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk("read pslverr", {31'h0, e}, {31'h0, err});
      chk("read data", exp, rd & m);
   endtask

   task automatic hw_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // whole run is under two hundred cycles; this limit is far beyond it
   initial begin
      #200000;
      fails++;
      $display("MISMATCH watchdog expected done seen hang");
      wrap_up();
   end

   initial begin
      logic [15:0] w;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk("reset mode", 32'h1, {31'h0, ctrl_reset_mode});
      rd_chk(A_BCC, 32'hFFFFE000, 32'h0, 1'b0);
      chk("pins after reset", 32'h0, {16'h0, pins & 16'hA000});
      $display("test reset_values done");

      for (int i = 0; i < 16; i++) begin
         w = 16'h0001 << i;
         wr_chk(A_BCC, {16'h0, w}, 1'b0);
         rd_chk(A_BCC, ALL, {16'h0, w & 16'hBFFF}, 1'b0);
         chk("field pins", {16'h0, w & 16'hBFFF}, {16'h0, pins});
      end
      wr_chk(A_BCC, ALL, 1'b0);
      rd_chk(A_BCC, ALL, 32'h0000BFFF, 1'b0);
      $display("test field_walk done");

      wr_chk(A_CMD, 32'h1, 1'b0);
      rd_chk(A_BCC, ALL, 32'h0000BFFF, 1'b0);
      chk("reset mode kept", 32'h1, {31'h0, ctrl_reset_mode});
      $display("test soft_reset done");

      wr_chk(A_CMD, 32'h0, 1'b0);
      // the command write lands at the edge that ends the transfer
      @(posedge pclk);
      chk("reset mode left", 32'h0, {31'h0, ctrl_reset_mode});
      wr_chk(A_BCC, 32'h0, 1'b1);
      rd_chk(A_BCC, ALL, 32'h0000BFFF, 1'b1);
      chk("pins unchanged", 32'h0000BFFF, {16'h0, pins});
      rd_chk(A_STAT, 32'h3, 32'h3, 1'b0);
      wr_chk(A_STAT, 32'h1, 1'b0);
      rd_chk(A_STAT, 32'h3, 32'h2, 1'b0);
      wr_chk(A_CMD, 32'h1, 1'b0);
      rd_chk(A_BAD, ALL, 32'h0, 1'b1);
      wr_chk(A_BAD, ALL, 1'b1);
      rd_chk(A_BCC, ALL, 32'h0000BFFF, 1'b0);
      $display("test access_guard done");

      hw_reset();
      rd_chk(A_STAT, 32'h2, 32'h0, 1'b0);
      rd_chk(A_BCC, ALL, 32'h00001FFF, 1'b0);
      chk("pins after hw reset", 32'h00001FFF, {16'h0, pins});
      wr_chk(A_BCC, 32'h00001234, 1'b0);
      // enable low right after the write: pins must hold the old word
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("pins frozen", 32'h00001FFF, {16'h0, pins});
      chk("pready frozen", 32'h0, {31'h0, pready});
      clk_en <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("pins released", 32'h00001234, {16'h0, pins});
      rd_chk(A_BCC, ALL, 32'h00001234, 1'b0);
      rd_chk(A_STAT, 32'h2, 32'h2, 1'b0);
      $display("test hw_reset done");
      wrap_up();
   end
endmodule
